/* verilog/tpm_defs.svh */
// constants of the trip priority manager: offsets, fields, resets, timing
// assumes one 40 MHz control clock and word-aligned bus offsets
`ifndef TPM_DEFS_SVH
`define TPM_DEFS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, low eight bits decoded)
// ----------------------------------------------------------------
`define TPM_OFS_CONFIG 8'h00
`define TPM_OFS_MENU_ZERO 8'h04
`define TPM_OFS_DEFAULTS_LOAD 8'h08
`define TPM_OFS_COMMAND 8'h0C
`define TPM_OFS_STATUS 8'h10

// ----------------------------------------------------------------
// configuration and command fields
// ----------------------------------------------------------------
`define TPM_CFG_WIDTH 7
`define TPM_CFG_STOP_BIT0 0
`define TPM_CFG_STOP_BIT1 1
`define TPM_CFG_LV_SELECT 2
`define TPM_CFG_DRIVE_ENABLE 3
`define TPM_CFG_CONTROL_WORD 4
`define TPM_CFG_LV_REQUEST 5
`define TPM_CFG_POWERUP_DONE 6
`define TPM_CMD_TRIP_RESET 0

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define TPM_CFG_RESET 7'h00
`define TPM_SETTING_RESET 16'h0000
`define TPM_DEFAULTS_CODE 16'h04D2
`define TPM_PRIO_NONE 3'h0
`define TPM_PRIO_HW 3'h1
`define TPM_PRIO_NON_RESET 3'h2
`define TPM_PRIO_NVSTORE 3'h3
`define TPM_PRIO_FOUR 3'h4
`define TPM_PRIO_FIVE 3'h5
`define TPM_PRIO_UV 3'h6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define TPM_CLK_HZ 40000000
`define TPM_LOCK_SHORT_MS 1000
`define TPM_LOCK_LONG_MS 10000
`define TPM_STOP_WAIT_MS 10000
`define TPM_CNT_WIDTH 29

`endif

/* verilog/tpm_pkg.sv */
// types of the trip priority manager
// assumes tpm_defs.svh is on the include path
`include "tpm_defs.svh"

package tpm_pkg;

  typedef enum logic [3:0] {
    CAT_NONE = 4'h0,
    CAT_HW_FAULT = 4'h1,
    CAT_NON_RESET = 4'h2,
    CAT_NVSTORE = 4'h3,
    CAT_CARD = 4'h4,
    CAT_ENC_SUPPLY = 4'h5,
    CAT_AUTOTUNE = 4'h6,
    CAT_EXT_RESET = 4'h7,
    CAT_NORMAL = 4'h8,
    CAT_NON_IMPORTANT = 4'h9,
    CAT_PHASE_LOSS = 4'hA,
    CAT_THERMAL = 4'hB,
    CAT_ENC_FEEDBACK = 4'hC,
    CAT_UNDERVOLT = 4'hD
  } tpm_cat_type;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_STOP = 2'h1,
    ST_TRIP = 2'h3
  } tpm_fsm_type;

  typedef struct packed {
    logic valid;
    tpm_cat_type cat;
    logic [7:0] code;
  } tpm_trip_req_type;

  typedef struct packed {
    tpm_fsm_type fsm;
    tpm_cat_type curCat;
    logic [7:0] curCode;
    logic [2:0] curPrio;
    tpm_cat_type pendCat;
    logic [7:0] pendCode;
    logic [`TPM_CNT_WIDTH-1:0] lockCnt;
    logic [`TPM_CNT_WIDTH-1:0] stopCnt;
    logic runInhibit;
    logic uvCond;
    logic [1:0] initCnt;
    logic savePulse;
    logic supplyLowVolt;
    logic defaultsArmed;
    logic [`TPM_CFG_WIDTH-1:0] cfg;
    logic [15:0] menuZero;
    logic [15:0] defaultsLoad;
    logic [2:0] syncA;
    logic [2:0] syncB;
    logic dpWrite;
    logic [7:0] dpAddr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic motorEnable;
    logic healthRelay;
    logic serialEnable;
    logic stopRequest;
  } tpm_state_type;

endpackage

/* verilog/tpm_trip_manager.sv */
// trip priority manager: ranks trips, gates resets, handles undervoltage
// assumes an AHB-Lite master on core_clk and fault sources on core_clk;
// safe torque off, bus level and motor stopped arrive as raw pins
//
// What this block does
// - priority-1 hardware trips never reset; motor off, relay open, serial off
// - priority-2 trips ignore every reset; only power-up reset clears them
// - nonvolatile store trip resets only after a defaults code is written
// - card trips are priority 4, resettable after 1.0 s; priority 5 in power-up
// - encoder supply trips priority 4; of priority-5 trips displace only encoder feedback
// - autotune trips reset after 1.0 s, then run blocked until a disable
// - extended-reset overcurrent trips accept reset only after 10.0 s
// - non-important trips stop the motor first when setting bit 0 is one
// - phase loss stops the motor first, then trips
// - thermal-model overheat stops first, trips anyway after 10 s
// - undervoltage is priority 6, ignores user reset, clears itself
// - during undervoltage everything runs except the motor output; the undervoltage trip opens the health relay
// - undervoltage entry with no other trip active saves power-down data unless low voltage supply selected
// - undervoltage clears when bus recovers; any other active trip stays
// - supply source changes only while the undervoltage flag is one
// - undervoltage shows as the trip only if no other trip is active
// - power-up undervoltage trip raised if bus low, without the save
// - new trip taken only if untripped or of lower priority number
`timescale 1ns/10ps
`include "tpm_defs.svh"

module tpm_trip_manager
  import tpm_pkg::*;
#(
  parameter logic [`TPM_CNT_WIDTH-1:0] LOCK_SHORT_CYC =
    `TPM_CNT_WIDTH'(`TPM_LOCK_SHORT_MS * (`TPM_CLK_HZ / 1000)),
  parameter logic [`TPM_CNT_WIDTH-1:0] LOCK_LONG_CYC =
    `TPM_CNT_WIDTH'(`TPM_LOCK_LONG_MS * (`TPM_CLK_HZ / 1000)),
  parameter logic [`TPM_CNT_WIDTH-1:0] STOP_WAIT_CYC =
    `TPM_CNT_WIDTH'(`TPM_STOP_WAIT_MS * (`TPM_CLK_HZ / 1000))
) (
  input wire logic core_clk, // control clock, 40 MHz
  input wire logic rst_b, // power-up reset, async, low
  input wire logic hsel, // ahb select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size, word only
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb bus ready
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb slave ready
  output logic hresp, // ahb response, always okay
  input wire tpm_trip_req_type tripReq, // trip request pulse
  input wire logic safeTorqueOff, // pin: torque off active
  input wire logic busAboveRestart, // pin: bus above restart level
  input wire logic motorStopped, // pin: power stage sees standstill
  output tpm_cat_type activeCat, // category of active trip
  output logic [7:0] faultCode, // code of active trip
  output logic [2:0] tripPriority, // priority, zero when none
  output logic motorOutputEnable, // power stage may switch
  output logic healthRelayClosed, // health relay contact
  output logic serialEnable, // serial link allowed
  output logic stopRequest, // ramp motor down before trip
  output logic savePowerDown, // pulse: save power-down data
  output logic undervoltageActive, // undervoltage active flag
  output logic supplyLowVoltage // supply source low voltage
);

  localparam tpm_state_type STATE_RESET = '{
    hreadyout: 1'b1,
    healthRelay: 1'b1,
    serialEnable: 1'b1,
    cfg: `TPM_CFG_RESET,
    menuZero: `TPM_SETTING_RESET,
    defaultsLoad: `TPM_SETTING_RESET,
    fsm: ST_RUN,
    curCat: CAT_NONE,
    pendCat: CAT_NONE,
    default: '0
  };

  tpm_state_type st_q;
  tpm_state_type st_d;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // card trips sit at priority 5 until power-up is marked done
  function automatic logic [2:0] catPrio(tpm_cat_type cat, logic powerUp);
    logic [2:0] p;
    p = `TPM_PRIO_FIVE;
    case (cat)
      CAT_HW_FAULT: p = `TPM_PRIO_HW;
      CAT_NON_RESET: p = `TPM_PRIO_NON_RESET;
      CAT_NVSTORE: p = `TPM_PRIO_NVSTORE;
      CAT_CARD: p = powerUp ? `TPM_PRIO_FIVE : `TPM_PRIO_FOUR;
      CAT_ENC_SUPPLY: p = `TPM_PRIO_FOUR;
      CAT_UNDERVOLT: p = `TPM_PRIO_UV;
      default: p = `TPM_PRIO_FIVE;
    endcase
    return p;
  endfunction

  function automatic tpm_state_type latchTrip(tpm_state_type s,
      tpm_cat_type cat, logic [7:0] code, logic [2:0] prio);
    tpm_state_type r;
    r = s;
    r.fsm = ST_TRIP;
    r.curCat = cat;
    r.curCode = code;
    r.curPrio = prio;
    // any stop still pending is dropped with the latch
    r.pendCat = CAT_NONE;
    r.lockCnt = '0;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic sto;
  logic busOk;
  logic stopped;
  logic addrPhase;
  logic resetReq;
  logic lockDone;
  logic resetOk;
  logic initReady;
  logic firstEval;
  logic powerUp;
  logic stopFirst;
  logic overrides;
  logic accept;
  logic tripNow;
  logic [2:0] newPrio;
  logic [`TPM_CNT_WIDTH-1:0] lockTarget;

  always_comb begin
    st_d = st_q;
    st_d.savePulse = 1'b0;
    resetReq = 1'b0;
    resetOk = 1'b0;

    // pin synchronisers
    // only the second stage feeds logic; the first may be metastable
    st_d.syncA = {safeTorqueOff, busAboveRestart, motorStopped};
    st_d.syncB = st_q.syncA;
    sto = st_q.syncB[2];
    busOk = st_q.syncB[1];
    stopped = st_q.syncB[0];
    // hold off undervoltage until the synced bus level is real
    if (st_q.initCnt != 2'h3) begin
      st_d.initCnt = st_q.initCnt + 2'h1;
    end
    initReady = st_q.initCnt[1];
    firstEval = (st_q.initCnt == 2'h2);
    powerUp = !st_q.cfg[`TPM_CFG_POWERUP_DONE];

    // ahb slave, zero wait states
    // word transfers only; narrow ones are dropped
    addrPhase = hsel && htrans[1] && hready && hsize == 3'h2;
    // write lands at the end of the data phase
    st_d.dpWrite = addrPhase && hwrite;
    st_d.dpAddr = haddr[7:0];
    if (st_q.dpWrite) begin
      if (st_q.dpAddr == `TPM_OFS_CONFIG) begin
        st_d.cfg = hwdata[`TPM_CFG_WIDTH-1:0];
      end else if (st_q.dpAddr == `TPM_OFS_MENU_ZERO) begin
        st_d.menuZero = hwdata[15:0];
        if (hwdata[15:0] == `TPM_DEFAULTS_CODE) begin
          st_d.defaultsArmed = 1'b1;
        end
      end else if (st_q.dpAddr == `TPM_OFS_DEFAULTS_LOAD) begin
        st_d.defaultsLoad = hwdata[15:0];
        if (hwdata[15:0] == `TPM_DEFAULTS_CODE) begin
          st_d.defaultsArmed = 1'b1;
        end
      end else if (st_q.dpAddr == `TPM_OFS_COMMAND) begin
        resetReq = hwdata[`TPM_CMD_TRIP_RESET];
      end
    end
    // read data registered here stands through the data phase
    if (addrPhase && !hwrite) begin
      if (haddr[7:0] == `TPM_OFS_CONFIG) begin
        st_d.hrdata = {25'h0000000, st_q.cfg};
      end else if (haddr[7:0] == `TPM_OFS_MENU_ZERO) begin
        st_d.hrdata = {16'h0000, st_q.menuZero};
      end else if (haddr[7:0] == `TPM_OFS_DEFAULTS_LOAD) begin
        st_d.hrdata = {16'h0000, st_q.defaultsLoad};
      end else if (haddr[7:0] == `TPM_OFS_STATUS) begin
        // live trip view for polling software
        st_d.hrdata = {10'h000, st_q.defaultsArmed, st_q.supplyLowVolt,
          lockDoneNow(st_q), st_q.fsm == ST_STOP, st_q.runInhibit,
          st_q.uvCond, st_q.curCode, st_q.curCat, st_q.curPrio,
          st_q.fsm == ST_TRIP};
      end else begin
        st_d.hrdata = 32'h00000000;
      end
    end
    st_d.hreadyout = 1'b1;
    st_d.hresp = 1'b0;

    // reset lockout
    lockTarget = (st_q.curCat == CAT_EXT_RESET) ? LOCK_LONG_CYC
      : LOCK_SHORT_CYC;
    lockDone = (st_q.lockCnt >= lockTarget);
    // counter stops at the limit so a late reset still sees expiry
    if (st_q.fsm == ST_TRIP && !lockDone) begin
      st_d.lockCnt = st_q.lockCnt + `TPM_CNT_WIDTH'(1);
    end

    // user reset of the active trip
    // a request during lockout is simply lost; software must retry
    if (resetReq && st_q.fsm == ST_TRIP) begin
      case (st_q.curCat)
        CAT_HW_FAULT: resetOk = 1'b0;
        CAT_NON_RESET: resetOk = 1'b0;
        CAT_UNDERVOLT: resetOk = 1'b0;
        CAT_NVSTORE: resetOk = st_q.defaultsArmed;
        default: resetOk = lockDone;
      endcase
    end
    // disable releases the inhibit; placed first so a same-cycle set wins
    if (st_q.runInhibit && (sto || !st_q.cfg[`TPM_CFG_DRIVE_ENABLE]
        || !st_q.cfg[`TPM_CFG_CONTROL_WORD])) begin
      st_d.runInhibit = 1'b0;
    end
    if (resetOk) begin
      if (st_q.curCat == CAT_AUTOTUNE) begin
        st_d.runInhibit = 1'b1;
      end
      if (st_q.curCat == CAT_NVSTORE) begin
        st_d.defaultsArmed = 1'b0;
      end
      st_d.fsm = ST_RUN;
      st_d.curCat = CAT_NONE;
      st_d.curCode = 8'h00;
      st_d.curPrio = `TPM_PRIO_NONE;
    end

    // undervoltage
    // flag follows the bus even while another trip owns the outputs
    if (initReady && !busOk && !st_q.uvCond) begin
      st_d.uvCond = 1'b1;
      if (st_q.fsm != ST_TRIP) begin
        st_d = latchTrip(st_d, CAT_UNDERVOLT, 8'h00,
          `TPM_PRIO_UV);
        // the first evaluation after power-up never saves
        if (!firstEval && !st_q.cfg[`TPM_CFG_LV_SELECT]) begin
          st_d.savePulse = 1'b1;
        end
      end
    end
    if (initReady && busOk && st_q.uvCond) begin
      st_d.uvCond = 1'b0;
      // self-clear touches the undervoltage trip alone
      if (st_q.curCat == CAT_UNDERVOLT) begin
        st_d.fsm = ST_RUN;
        st_d.curCat = CAT_NONE;
        st_d.curPrio = `TPM_PRIO_NONE;
      end
    end
    if (st_q.uvCond) begin
      st_d.supplyLowVolt = st_q.cfg[`TPM_CFG_LV_REQUEST];
    end

    // stop before trip
    // limit minus one: the latch edge itself is the last stop cycle
    if (st_q.fsm == ST_STOP) begin
      st_d.stopCnt = st_q.stopCnt + `TPM_CNT_WIDTH'(1);
      if (stopped || (st_q.pendCat == CAT_THERMAL
          && st_q.stopCnt >= STOP_WAIT_CYC - `TPM_CNT_WIDTH'(1))) begin
        st_d = latchTrip(st_d, st_q.pendCat, st_q.pendCode,
          `TPM_PRIO_FIVE);
      end
    end

    // new trip arbitration
    newPrio = catPrio(tripReq.cat, powerUp);
    overrides = (newPrio < st_q.curPrio) && !(tripReq.cat == CAT_ENC_SUPPLY
      && st_q.curPrio == `TPM_PRIO_FIVE
      && st_q.curCat != CAT_ENC_FEEDBACK);
    // undervoltage is raised from the bus pin only, never by request
    accept = tripReq.valid && tripReq.cat != CAT_NONE
      && tripReq.cat != CAT_UNDERVOLT
      && (st_q.fsm != ST_TRIP || overrides);
    stopFirst = tripReq.cat == CAT_PHASE_LOSS
      || tripReq.cat == CAT_THERMAL
      || (tripReq.cat == CAT_NON_IMPORTANT
      && st_q.cfg[`TPM_CFG_STOP_BIT0]);
    if (accept) begin
      if (stopFirst && st_q.fsm == ST_RUN) begin
        st_d.fsm = ST_STOP;
        st_d.pendCat = tripReq.cat;
        st_d.pendCode = tripReq.code;
        st_d.stopCnt = '0;
      end else if (!(stopFirst && st_q.fsm == ST_STOP)) begin
        st_d = latchTrip(st_d, tripReq.cat, tripReq.code, newPrio);
      end
    end

    // output stage
    // built from next state so the outputs move on the latch edge
    tripNow = (st_d.fsm == ST_TRIP);
    st_d.motorEnable = !tripNow && st_d.fsm != ST_STOP && !st_d.runInhibit
      && !st_d.uvCond && !sto && st_d.cfg[`TPM_CFG_DRIVE_ENABLE]
      && st_d.cfg[`TPM_CFG_CONTROL_WORD];
    st_d.healthRelay = !tripNow;
    st_d.serialEnable = !(tripNow
      && st_d.curPrio == `TPM_PRIO_HW);
    st_d.stopRequest = (st_d.fsm == ST_STOP);
  end

  // same limit as the lockout path, for the status bit
  function automatic logic lockDoneNow(tpm_state_type s);
    logic [`TPM_CNT_WIDTH-1:0] t;
    t = (s.curCat == CAT_EXT_RESET) ? LOCK_LONG_CYC : LOCK_SHORT_CYC;
    return s.lockCnt >= t;
  endfunction

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hrdata = st_q.hrdata;
  assign hreadyout = st_q.hreadyout;
  assign hresp = st_q.hresp;
  assign activeCat = st_q.curCat;
  assign faultCode = st_q.curCode;
  assign tripPriority = st_q.curPrio;
  assign motorOutputEnable = st_q.motorEnable;
  assign healthRelayClosed = st_q.healthRelay;
  assign serialEnable = st_q.serialEnable;
  assign stopRequest = st_q.stopRequest;
  assign savePowerDown = st_q.savePulse;
  assign undervoltageActive = st_q.uvCond;
  assign supplyLowVoltage = st_q.supplyLowVolt;

endmodule

/* dv/tpm_trip_manager_props.sv */
// checker of the trip priority manager outputs
// assumes a bind onto tpm_trip_manager with one clock domain
`timescale 1ns/10ps
`include "tpm_defs.svh"

module tpm_trip_props
  import tpm_pkg::*;
#(
  parameter logic [`TPM_CNT_WIDTH-1:0] LOCK_SHORT_CYC = 29'h14,
  parameter logic [`TPM_CNT_WIDTH-1:0] LOCK_LONG_CYC = 29'hC8,
  parameter logic [`TPM_CNT_WIDTH-1:0] STOP_WAIT_CYC = 29'h32
) (
  input wire logic core_clk, // clock
  input wire logic rst_b, // reset, low
  input wire tpm_cat_type activeCat, // category
  input wire logic [2:0] tripPriority, // priority
  input wire logic motorOutputEnable, // stage on
  input wire logic healthRelayClosed, // relay
  input wire logic serialEnable, // serial on
  input wire logic stopRequest, // stopping
  input wire logic savePowerDown, // save pulse
  input wire logic undervoltageActive, // uv flag
  input wire logic supplyLowVoltage // source
);
  logic [`TPM_CNT_WIDTH-1:0] sinceCnt_q;
  logic [`TPM_CNT_WIDTH-1:0] stopCnt_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  // cycles since priority last moved, cycles spent stopping
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sinceCnt_q <= '0;
      stopCnt_q <= '0;
    end else begin
      sinceCnt_q <= $changed(tripPriority) ? '0 : sinceCnt_q + 1'b1;
      stopCnt_q <= stopRequest ? stopCnt_q + 1'b1 : '0;
    end
  end

  property p_hw;
    tripPriority == 3'h1 |-> !serialEnable && !healthRelayClosed
      && !motorOutputEnable;
  endproperty
  a_hw: assert property (p_hw) else $error("hw trip outputs");

  property p_nores;
    tripPriority == 3'h2 |=> tripPriority inside {3'h1, 3'h2};
  endproperty
  a_nores: assert property (p_nores) else $error("prio 2 left");

  property p_gate;
    motorOutputEnable |-> tripPriority == 3'h0 && !stopRequest
      && !undervoltageActive;
  endproperty
  a_gate: assert property (p_gate) else $error("stage on");

  property p_supply;
    $changed(supplyLowVoltage) |-> undervoltageActive
      || $past(undervoltageActive);
  endproperty
  a_supply: assert property (p_supply) else $error("source");

  property p_save;
    savePowerDown |=> !savePowerDown;
  endproperty
  a_save: assert property (p_save) else $error("save width");

  property p_ovr;
    $past(tripPriority) != 3'h0 && tripPriority != 3'h0
      && $changed(tripPriority) |-> tripPriority < $past(tripPriority);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override");

  property p_short;
    $past(tripPriority) inside {3'h4, 3'h5} && tripPriority == 3'h0
      |-> $past(sinceCnt_q) >= LOCK_SHORT_CYC - 3;
  endproperty
  a_short: assert property (p_short) else $error("early");

  property p_long;
    $past(activeCat) == CAT_EXT_RESET && $past(tripPriority) != 3'h0
      && tripPriority == 3'h0 |-> $past(sinceCnt_q) >= LOCK_LONG_CYC - 3;
  endproperty
  a_long: assert property (p_long) else $error("early ext");

  property p_stop;
    stopRequest |-> stopCnt_q < STOP_WAIT_CYC + 4;
  endproperty
  a_stop: assert property (p_stop) else $error("stop long");
endmodule

bind tpm_trip_manager tpm_trip_props #(
  .LOCK_SHORT_CYC(LOCK_SHORT_CYC),
  .LOCK_LONG_CYC(LOCK_LONG_CYC),
  .STOP_WAIT_CYC(STOP_WAIT_CYC)
) i_props (
  .core_clk, .rst_b, .activeCat, .tripPriority, .motorOutputEnable,
  .healthRelayClosed, .serialEnable, .stopRequest, .savePowerDown,
  .undervoltageActive, .supplyLowVoltage
);

/* dv/tpm_plant_model.sv */
// plant model: power stage and motor behind the trip manager
// assumes stop demand and stage enable arrive on core_clk
`timescale 1ns/10ps

module tpm_plant_model (
  input wire logic core_clk, // control clock
  input wire logic stopRequest, // ramp-down demand
  input wire logic motorOutputEnable, // stage may switch
  input wire logic stallStop, // motor refuses to stop
  output logic motorStopped // standstill seen
);
  logic [2:0] spinCnt_q = 3'h0;

  // motor reaches rest four cycles after drive is withdrawn
  always_ff @(posedge core_clk) begin
    if ((stopRequest || !motorOutputEnable) && !stallStop) begin
      spinCnt_q <= (spinCnt_q == 3'h4) ? spinCnt_q : spinCnt_q + 3'h1;
    end else begin
      spinCnt_q <= 3'h0;
    end
  end
  assign motorStopped = (spinCnt_q == 3'h4);
endmodule

/* dv/test_trip_priority_manager.sv */
// self-checking bench of the trip priority manager
// assumes design, checker and plant model are compiled first
`timescale 1ns/10ps
`include "tpm_defs.svh"

module test_trip_priority_manager
  import tpm_pkg::*;
;
  localparam int SHORT = 20;
  localparam int LONG = 200;
  localparam int STOPW = 50;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic safeTorqueOff = 1'b0;
  logic busAboveRestart = 1'b1;
  logic stall = 1'b0;
  logic [31:0] hrdata, rd;
  logic hready, hreadyout, hresp, motorStopped;
  tpm_trip_req_type tripReq = '0;
  tpm_cat_type activeCat;
  logic [7:0] faultCode;
  logic [2:0] tripPriority;
  logic motorOutputEnable, healthRelayClosed, serialEnable, stopRequest;
  logic savePowerDown, undervoltageActive, supplyLowVoltage;
  int fails = 0;
  int cmp_count = 0;
  int saves = 0;
  int s0;

  assign hready = hreadyout;

  tpm_trip_manager #(
    .LOCK_SHORT_CYC(`TPM_CNT_WIDTH'(SHORT)),
    .LOCK_LONG_CYC(`TPM_CNT_WIDTH'(LONG)),
    .STOP_WAIT_CYC(`TPM_CNT_WIDTH'(STOPW))
  ) i_dut (
    .core_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .tripReq, .safeTorqueOff,
    .busAboveRestart, .motorStopped, .activeCat, .faultCode, .tripPriority,
    .motorOutputEnable, .healthRelayClosed, .serialEnable, .stopRequest,
    .savePowerDown, .undervoltageActive, .supplyLowVoltage
  );

  tpm_plant_model i_plant (
    .core_clk, .stopRequest, .motorOutputEnable, .stallStop(stall),
    .motorStopped
  );

  initial forever #12.5 core_clk = ~core_clk;

  always @(posedge core_clk) if (savePowerDown === 1'b1) saves++;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask

  task rs;
    bus(1'b1, `TPM_OFS_COMMAND, 32'h1);
  endtask

  task cf(input logic [31:0] v);
    bus(1'b1, `TPM_OFS_CONFIG, v);
  endtask

  task tr(input tpm_cat_type c, input logic [7:0] code);
    @(posedge core_clk);
    tripReq <= {1'b1, c, code};
    @(posedge core_clk);
    tripReq <= '0;
    wt(2);
  endtask

  task cp(input logic [2:0] e);
    repeat (2) @(negedge core_clk);
    chk(32'(tripPriority), 32'(e));
  endtask

  // wait out the short lockout, then reset the trip
  task clr;
    wt(SHORT);
    rs;
    cp(3'h0);
  endtask

  task fin(input string s);
    $display("test %s done", s);
  endtask

  task t_reg;
    cf(32'h58);
    bus(1'b0, `TPM_OFS_CONFIG, '0);
    chk(rd, 32'h58);
    bus(1'b0, 8'h40, '0);
    chk(rd, 32'h0);
    chk(32'(hresp), 32'h0);
    wt(6);
    @(negedge core_clk);
    chk(32'(motorOutputEnable), 32'h1);
    fin("reg");
  endtask

  task t_norm;
    tr(CAT_NORMAL, 8'h21);
    cp(3'h5);
    chk(32'(motorOutputEnable), 32'h0);
    rs;
    wt(SHORT);
    cp(3'h5);
    bus(1'b0, `TPM_OFS_STATUS, '0);
    chk(rd, 32'h0008218B);
    clr;
    fin("normal");
  endtask

  task t_ovr;
    tr(CAT_ENC_FEEDBACK, 8'hC1);
    tr(CAT_ENC_SUPPLY, 8'hBD);
    cp(3'h4);
    tr(CAT_NORMAL, 8'h22);
    cp(3'h4);
    chk(32'(activeCat), 32'(CAT_ENC_SUPPLY));
    chk(32'(faultCode), 32'hBD);
    clr;
    tr(CAT_NORMAL, 8'h22);
    tr(CAT_ENC_SUPPLY, 8'hBD);
    cp(3'h5);
    tr(CAT_CARD, 8'hAF);
    cp(3'h4);
    clr;
    cf(32'h18);
    tr(CAT_CARD, 8'hAF);
    cp(3'h5);
    clr;
    cf(32'h58);
    fin("override");
  endtask

  task t_ext;
    tr(CAT_EXT_RESET, 8'h03);
    wt(SHORT + 5);
    rs;
    cp(3'h5);
    wt(LONG);
    rs;
    cp(3'h0);
    fin("extended");
  endtask

  task t_nv;
    tr(CAT_NVSTORE, 8'h1F);
    wt(SHORT);
    rs;
    cp(3'h3);
    bus(1'b1, `TPM_OFS_DEFAULTS_LOAD, 32'(`TPM_DEFAULTS_CODE));
    rs;
    cp(3'h0);
    tr(CAT_NVSTORE, 8'h1F);
    bus(1'b1, `TPM_OFS_MENU_ZERO, 32'(`TPM_DEFAULTS_CODE));
    rs;
    cp(3'h0);
    fin("nvstore");
  endtask

  task t_auto;
    tr(CAT_AUTOTUNE, 8'h0B);
    clr;
    wt(4);
    @(negedge core_clk);
    chk(32'(motorOutputEnable), 32'h0);
    cf(32'h50);
    cf(32'h58);
    wt(4);
    @(negedge core_clk);
    chk(32'(motorOutputEnable), 32'h1);
    fin("autotune");
  endtask

  task t_stop;
    tpm_cat_type sc[2];
    sc = '{CAT_NON_IMPORTANT, CAT_PHASE_LOSS};
    tr(CAT_NON_IMPORTANT, 8'h18);
    cp(3'h5);
    clr;
    cf(32'h59);
    foreach (sc[i]) begin
      wt(6);
      tr(sc[i], 8'h20);
      @(negedge core_clk);
      chk(32'({stopRequest, tripPriority}), 32'h8);
      wt(12);
      cp(3'h5);
      clr;
    end
    wt(6);
    stall <= 1'b1;
    tr(CAT_THERMAL, 8'h1B);
    cp(3'h0);
    wt(STOPW);
    cp(3'h5);
    stall <= 1'b0;
    clr;
    cf(32'h58);
    fin("stop");
  endtask

  task t_uv;
    @(posedge core_clk);
    busAboveRestart <= 1'b0;
    s0 = saves;
    wt(8);
    cp(3'h6);
    chk(32'(undervoltageActive), 32'h1);
    chk(saves, s0 + 1);
    rs;
    cp(3'h6);
    cf(32'h78);
    wt(4);
    busAboveRestart <= 1'b1;
    wt(8);
    cp(3'h0);
    chk(32'(supplyLowVoltage), 32'h1);
    cf(32'h58);
    wt(4);
    @(negedge core_clk);
    chk(32'(supplyLowVoltage), 32'h1);
    tr(CAT_NORMAL, 8'h30);
    busAboveRestart <= 1'b0;
    wt(8);
    cp(3'h5);
    chk(32'(undervoltageActive), 32'h1);
    @(posedge core_clk);
    busAboveRestart <= 1'b1;
    wt(8);
    cp(3'h5);
    clr;
    cf(32'h5C);
    busAboveRestart <= 1'b0;
    s0 = saves;
    wt(8);
    cp(3'h6);
    chk(saves, s0);
    @(posedge core_clk);
    busAboveRestart <= 1'b1;
    wt(8);
    cp(3'h0);
    cf(32'h58);
    fin("undervoltage");
  endtask

  task t_hw;
    tr(CAT_NON_RESET, 8'hC8);
    cp(3'h2);
    tr(CAT_NON_RESET, 8'hC8);
    wt(SHORT);
    rs;
    cp(3'h2);
    tr(CAT_HW_FAULT, 8'h05);
    wt(SHORT);
    rs;
    cp(3'h1);
    chk(32'({serialEnable, healthRelayClosed}), 32'h0);
    @(posedge core_clk);
    busAboveRestart <= 1'b0;
    rst_b <= 1'b0;
    wt(6);
    cp(3'h0);
    s0 = saves;
    @(posedge core_clk);
    rst_b <= 1'b1;
    wt(10);
    cp(3'h6);
    chk(saves, s0);
    fin("hardware");
  endtask

  task results;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (8000) @(posedge core_clk);
    fails++;
    results;
  end

  initial begin
    wt(6);
    rst_b <= 1'b1;
    t_reg;
    t_norm;
    t_ovr;
    t_ext;
    t_nv;
    t_auto;
    t_stop;
    t_uv;
    t_hw;
    results;
  end
endmodule
